// file: design/cbf_byte_dec.sv
// Byte write enable decoder
`timescale 1ns/1ns
module cbf_byte_dec (
  input wire logic clk_sys, // System clock
  input wire logic reset_n, // Synchronous reset, active low
  input wire logic wr_en, // Cache write access this cycle
  input wire logic [2:0] addr_lo, // Low address bits
  input wire logic [1:0] access_size, // 00 byte .. 11 doubleword
  output logic [7:0] cache_byte_wr_en_n // Lane 0 is byte at N (bits 63:56)
);
  typedef struct packed {
    logic [7:0] be_n;
  } cbf_dec_st_t;
  cbf_dec_st_t st_reg;
  cbf_dec_st_t st_next;

  // Lane i set when its index lies inside the aligned span
  function automatic logic [7:0] cbf_lanes(input logic [1:0] sz, input logic [2:0] a);
    logic [7:0] m;
    m = 8'h00;
    for (int i = 0; i < 8; i++) begin
      unique case (sz)
        2'b00: m[i] = (3'(i) == a);
        2'b01: m[i] = (3'(i) >> 1) == (a >> 1);
        2'b10: m[i] = (3'(i) >> 2) == (a >> 2);
        2'b11: m[i] = 1'b1;
      endcase
    end
    return m;
  endfunction

  always_comb begin
    st_next = st_reg;
    st_next.be_n = 8'hFF;
    if (wr_en) begin
      st_next.be_n = ~cbf_lanes(access_size, addr_lo);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      st_reg <= '{be_n: 8'hFF};
    end else begin
      st_reg <= st_next;
    end
  end

  assign cache_byte_wr_en_n = st_reg.be_n;

  property p_byte_full;
    @(posedge clk_sys) disable iff (!reset_n)
      (wr_en && access_size == 2'b11) |=> (cache_byte_wr_en_n == 8'h00);
  endproperty
  a_byte_full: assert property (p_byte_full) else $error("doubleword lanes wrong");
  property p_byte_idle;
    @(posedge clk_sys) disable iff (!reset_n) !wr_en |=> (cache_byte_wr_en_n == 8'hFF);
  endproperty
  a_byte_idle: assert property (p_byte_idle) else $error("lanes active outside write");
  property p_byte_one;
    @(posedge clk_sys) disable iff (!reset_n)
      (wr_en && access_size == 2'b00) |=> (cache_byte_wr_en_n == ~(8'h01 << $past(addr_lo)));
  endproperty
  a_byte_one: assert property (p_byte_one) else $error("byte lane wrong");
endmodule // cbf_byte_dec

// file: design/cbf_cfg.svh
// Constants for the cache byte enable and forwarding block
`ifndef CBF_CFG_SVH
`define CBF_CFG_SVH
`define CBF_OFS_SCR 8'h00
`define CBF_OFS_ASYNC_FAULT_ADDR_REG 8'h04
`define CBF_OFS_ASYNC_FAULT_STATUS_REG 8'h08
`define CBF_OFS_IRQ_STAT 8'h0C
`define CBF_OFS_IRQ_CLR 8'h10
`define CBF_OFS_IRQ_EN 8'h14
`define CBF_OFS_ASI 8'h18
`define CBF_SCR_WRAP_BIT 21
`define CBF_ASYNC_FAULT_STATUS_REG_SE_BIT 13
`define CBF_ASYNC_FAULT_STATUS_REG_UC_BIT 0
`define CBF_ASYNC_FAULT_STATUS_REG_TO_BIT 1
`define CBF_ASYNC_FAULT_STATUS_REG_BE_BIT 2
`define CBF_ASYNC_FAULT_STATUS_REG_RR_BIT 3
`define CBF_SCR_RESET 32'h00004000
`define CBF_SCR_RO_MASK 32'hFF000000
`define CBF_CTRL_ASI 8'h04
`define CBF_LINE_BEATS 4
`endif

// file: design/cbf_pkg.sv
// Types for the cache byte enable and forwarding block
package cbf_pkg;
  typedef enum logic [1:0] {
    CBF_IDLE = 2'b00,
    CBF_FIRST = 2'b01,
    CBF_REST = 2'b10
  } cbf_state_t;
endpackage

// file: design/cbf_top.sv
// Cache byte enables, read miss forwarding and control registers
`timescale 1ns/1ns
`include "cbf_cfg.svh"
// Behaviour
// - Eight active-low byte write enables from low address and size.
// - Lane 0 is byte N (bits 63:56), lane 7 is N+7.
// - Byte one lane, halfword two, word four, doubleword all eight.
// - Forward read miss data only while wrap enable is set.
// - Line request starts at missed doubleword and wraps at line end.
// - Strobe first data to processor and release hold; fill continues.
// - For doubleword requests strobe every valid fill beat.
// - With wrap enable set, bus error after first beat acknowledged invalidates the line.
// - With wrap enable set, retry after first beat acknowledged becomes an asynchronous error.
// - Async error updates fault address, status and system error bit 13.
// - Control fields writable except hardwired implementation and version.
// - Control registers written only with alternate space identifier 4; read from any space.
// - Fault address and status registers are read-only.
// - A line is 32 bytes, four doubleword beats.
// - Wrap enable sits at bit 21 of system control register.
module cbf_top import cbf_pkg::*; #(
  parameter logic [3:0] IMPLEMENTATION_FIELD_ID = 4'h3, // Arbitrary value
  parameter logic [3:0] VER_ID = 4'h5 // Arbitrary value
) (
  input wire logic clk_sys, // System clock
  input wire logic reset_n, // Synchronous reset, active low
  input wire logic [7:0] wb_adr_i, // Wishbone byte address
  input wire logic [31:0] wb_dat_i, // Wishbone write data
  output logic [31:0] wb_dat_o, // Wishbone read data
  input wire logic wb_we_i, // Wishbone write
  input wire logic [3:0] wb_sel_i, // Wishbone byte selects
  input wire logic wb_cyc_i, // Wishbone cycle
  input wire logic wb_stb_i, // Wishbone strobe
  output logic wb_ack_o, // Wishbone acknowledge
  input wire logic [7:0] alt_space_id, // Space id of the processor access
  input wire logic cache_wr, // Processor cache write access
  input wire logic [31:0] internal_addr_bus, // Processor address
  input wire logic [1:0] access_size, // Access size
  output logic [7:0] cache_byte_wr_en_n, // Byte write enables, active low
  input wire logic miss_req, // Read miss pulse
  input wire logic miss_dw, // Processor asked for a doubleword
  output logic cpu_hold, // Pipeline hold
  output logic cpu_data_strobe, // Data strobe to processor
  output logic [63:0] internal_data_bus, // Data to processor and cache
  output logic cache_fill_we, // Write fill beat into cache
  output logic [1:0] cache_fill_beat, // Doubleword index in line
  output logic line_inval, // Invalidate the filled line, pulse
  output logic mem_req, // Line request to memory bus
  output logic [31:0] mem_addr, // Line request address
  input wire logic mem_ack, // Data beat acknowledged
  input wire logic [63:0] mem_data, // Beat data
  input wire logic uncorrectable_error, // Beat error: uncorrectable
  input wire logic timeout_error, // Beat error: timeout
  input wire logic bus_error, // Beat error: bus error
  input wire logic mem_retry, // Retry or relinquish response
  output logic irq // Level interrupt
);
  typedef struct packed {
    cbf_state_t st;
    logic [31:0] system_control_reg;
    logic [31:0] async_fault_addr_reg;
    logic [31:0] async_fault_status_reg;
    logic [1:0] irq_stat;
    logic [1:0] irq_en;
    logic [31:0] addr;
    logic [1:0] beat;
    logic fwd;
    logic dw;
    logic hold;
    logic strobe;
    logic [63:0] data;
    logic fill_we;
    logic inval;
    logic req;
    logic ack;
    logic [31:0] rdat;
  } cbf_top_st_t;
  cbf_top_st_t s_reg;
  cbf_top_st_t s_next;

  logic wb_hit;
  logic ctl_space;
  logic beat_err;
  logic late_err;
  logic [31:0] wdat;

  // Byte-select merge, used only by the system control register
  function automatic logic [31:0] cbf_merge(input logic [31:0] old,
                                            input logic [31:0] nw,
                                            input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction

  cbf_byte_dec u_dec (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .wr_en(cache_wr),
    .addr_lo(internal_addr_bus[2:0]),
    .access_size(access_size),
    .cache_byte_wr_en_n(cache_byte_wr_en_n)
  );

  assign ctl_space = (alt_space_id == `CBF_CTRL_ASI);
  assign wb_hit = wb_cyc_i && wb_stb_i && !s_reg.ack;
  assign beat_err = uncorrectable_error || timeout_error || bus_error;
  // Any error or retry once the first beat is behind us
  assign late_err = (s_reg.st == CBF_REST) && mem_ack && (beat_err || mem_retry);
  assign wdat = wb_dat_i;

  always_comb begin
    s_next = s_reg;
    s_next.ack = wb_hit;
    s_next.strobe = 1'b0;
    s_next.fill_we = 1'b0;
    s_next.inval = 1'b0;
    // Register bus; reads from any space, writes only from the control space
    if (wb_hit) begin
      s_next.rdat = 32'h00000000;
      unique case (wb_adr_i)
        `CBF_OFS_SCR: s_next.rdat = {IMPLEMENTATION_FIELD_ID, VER_ID, s_reg.system_control_reg[23:0]};
        `CBF_OFS_ASYNC_FAULT_ADDR_REG: s_next.rdat = s_reg.async_fault_addr_reg;
        `CBF_OFS_ASYNC_FAULT_STATUS_REG: s_next.rdat = s_reg.async_fault_status_reg;
        `CBF_OFS_IRQ_STAT: s_next.rdat = {30'h00000000, s_reg.irq_stat};
        `CBF_OFS_IRQ_EN: s_next.rdat = {30'h00000000, s_reg.irq_en};
        `CBF_OFS_ASI: s_next.rdat = {31'h00000000, ctl_space};
        default: s_next.rdat = 32'h00000000;
      endcase
      if (wb_we_i && ctl_space) begin
        unique case (wb_adr_i)
          `CBF_OFS_SCR: begin
            s_next.system_control_reg = cbf_merge(s_reg.system_control_reg, wdat, wb_sel_i) & ~`CBF_SCR_RO_MASK;
          end
          `CBF_OFS_IRQ_CLR: s_next.irq_stat = s_reg.irq_stat & ~wdat[1:0];
          `CBF_OFS_IRQ_EN: s_next.irq_en = wdat[1:0];
          default: ; // Fault registers ignore stores
        endcase
      end
    end
    unique case (s_reg.st)
      CBF_IDLE: begin
        if (miss_req) begin
          s_next.st = CBF_FIRST;
          s_next.addr = {internal_addr_bus[31:3], 3'b000};
          s_next.beat = internal_addr_bus[4:3];
          s_next.fwd = s_reg.system_control_reg[`CBF_SCR_WRAP_BIT];
          s_next.dw = miss_dw;
          s_next.hold = 1'b1;
          s_next.req = 1'b1;
        end
      end
      CBF_FIRST: begin
        if (mem_ack) begin
          s_next.req = 1'b0;
          s_next.data = mem_data;
          s_next.fill_we = !beat_err && !mem_retry;
          if (beat_err || mem_retry) begin
            // First beat errors are reported synchronously elsewhere
            s_next.st = CBF_IDLE;
            s_next.hold = 1'b0;
          end else begin
            s_next.beat = s_reg.beat + 2'd1;
            s_next.st = CBF_REST;
            if (s_reg.fwd) begin
              s_next.strobe = 1'b1;
              s_next.hold = 1'b0;
            end
          end
        end
      end
      CBF_REST: begin
        if (mem_ack) begin
          s_next.data = mem_data;
          s_next.fill_we = !late_err;
          s_next.strobe = s_reg.fwd && s_reg.dw && !late_err;
          s_next.beat = s_reg.beat + 2'd1;
          if (late_err || s_next.beat == s_reg.addr[4:3]) begin
            s_next.st = CBF_IDLE;
            s_next.hold = 1'b0;
          end
          if (late_err && s_reg.fwd) begin
            s_next.inval = 1'b1;
            s_next.async_fault_addr_reg = s_reg.addr;
            s_next.async_fault_status_reg = 32'h00000000;
            s_next.async_fault_status_reg[`CBF_ASYNC_FAULT_STATUS_REG_SE_BIT] = 1'b1;
            s_next.async_fault_status_reg[`CBF_ASYNC_FAULT_STATUS_REG_UC_BIT] = uncorrectable_error;
            s_next.async_fault_status_reg[`CBF_ASYNC_FAULT_STATUS_REG_TO_BIT] = timeout_error;
            s_next.async_fault_status_reg[`CBF_ASYNC_FAULT_STATUS_REG_BE_BIT] = bus_error;
            s_next.async_fault_status_reg[`CBF_ASYNC_FAULT_STATUS_REG_RR_BIT] = mem_retry;
          end
        end
      end
      default: s_next.st = CBF_IDLE;
    endcase
    // Event flags: set wins over a same-cycle clear
    if (s_next.inval) begin
      s_next.irq_stat[0] = 1'b1;
    end
    if (s_reg.st != CBF_IDLE && s_next.st == CBF_IDLE) begin
      s_next.irq_stat[1] = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      s_reg <= '0;
      s_reg.system_control_reg <= `CBF_SCR_RESET;
      s_reg.st <= CBF_IDLE;
    end else begin
      s_reg <= s_next;
    end
  end

  assign wb_ack_o = s_reg.ack;
  assign wb_dat_o = s_reg.rdat;
  assign cpu_hold = s_reg.hold;
  assign cpu_data_strobe = s_reg.strobe;
  assign internal_data_bus = s_reg.data;
  assign cache_fill_we = s_reg.fill_we;
  assign cache_fill_beat = s_reg.beat - 2'd1;
  assign line_inval = s_reg.inval;
  assign mem_req = s_reg.req;
  assign mem_addr = s_reg.addr;
  assign irq = |(s_reg.irq_stat & s_reg.irq_en);

  property p_wrap_gate;
    @(posedge clk_sys) disable iff (!reset_n)
      (s_reg.st == CBF_FIRST && mem_ack && !beat_err && !mem_retry && !s_reg.fwd)
        |=> !cpu_data_strobe && cpu_hold;
  endproperty
  a_wrap_gate: assert property (p_wrap_gate) else $error("forward without wrap");
  property p_first_fwd;
    @(posedge clk_sys) disable iff (!reset_n)
      (s_reg.st == CBF_FIRST && mem_ack && !beat_err && !mem_retry && s_reg.fwd)
        |=> cpu_data_strobe && !cpu_hold && cache_fill_we;
  endproperty
  a_first_fwd: assert property (p_first_fwd) else $error("first beat not forwarded");
  property p_miss_addr;
    @(posedge clk_sys) disable iff (!reset_n)
      (s_reg.st == CBF_IDLE && miss_req)
        |=> mem_req && mem_addr[31:3] == $past(internal_addr_bus[31:3]);
  endproperty
  a_miss_addr: assert property (p_miss_addr) else $error("line request address");
  logic async_se;
  assign async_se = s_reg.async_fault_status_reg[`CBF_ASYNC_FAULT_STATUS_REG_SE_BIT];
  property p_late;
    @(posedge clk_sys) disable iff (!reset_n)
      (late_err && s_reg.fwd) |=> line_inval && async_se && s_reg.st == CBF_IDLE;
  endproperty
  a_late: assert property (p_late) else $error("late error not handled");
  property p_ro;
    @(posedge clk_sys) disable iff (!reset_n)
      (wb_hit && wb_we_i && (wb_adr_i == `CBF_OFS_ASYNC_FAULT_ADDR_REG || wb_adr_i == `CBF_OFS_ASYNC_FAULT_STATUS_REG)
        && !late_err) |=> $stable(s_reg.async_fault_addr_reg) && $stable(s_reg.async_fault_status_reg);
  endproperty
  a_ro: assert property (p_ro) else $error("fault register written");
  property p_asi;
    @(posedge clk_sys) disable iff (!reset_n)
      (wb_hit && wb_we_i && !ctl_space) |=> $stable(s_reg.system_control_reg);
  endproperty
  a_asi: assert property (p_asi) else $error("write outside control space");
  property p_hw_id;
    @(posedge clk_sys) disable iff (!reset_n)
      (wb_hit && !wb_we_i && wb_adr_i == `CBF_OFS_SCR) |=> wb_dat_o[31:24] == {IMPLEMENTATION_FIELD_ID, VER_ID};
  endproperty
  a_hw_id: assert property (p_hw_id) else $error("hardwired id changed");
  property p_dw_strobe;
    @(posedge clk_sys) disable iff (!reset_n)
      (s_reg.st == CBF_REST && mem_ack && !late_err && s_reg.fwd && s_reg.dw)
        |=> cpu_data_strobe;
  endproperty
  a_dw_strobe: assert property (p_dw_strobe) else $error("fill beat not strobed");
  c_fwd: cover property (@(posedge clk_sys) disable iff (!reset_n) cpu_data_strobe ##1 cpu_data_strobe);
  c_late: cover property (@(posedge clk_sys) disable iff (!reset_n) line_inval);
  c_irq: cover property (@(posedge clk_sys) disable iff (!reset_n) irq);
endmodule // cbf_top

// file: sim/cbf_mem_model.sv
// Memory bus model answering line requests with wrapped beats
`timescale 1ns/1ns
module cbf_mem_model (
  input wire logic clk_sys, // System clock
  input wire logic reset_n, // Reset, active low
  input wire logic mem_req, // Line request
  input wire logic [31:0] mem_addr, // Missed doubleword address
  input wire logic [3:0] fill_gap, // Idle cycles before each beat
  input wire logic [2:0] err_beat, // Beat that carries an error, 4 none
  input wire logic [3:0] err_kind, // Retry, bus, timeout, uncorrectable
  output logic mem_ack, // Beat acknowledge
  output logic [63:0] mem_data, // Beat data
  output logic [3:0] beat_err, // Error qualifiers of the beat
  output logic busy // Fill in progress
);
  logic [31:0] base;
  logic [31:0] a;
  initial begin
    mem_ack = 1'b0;
    mem_data = 64'h0;
    beat_err = 4'h0;
    busy = 1'b0;
    forever begin
      @(posedge clk_sys);
      if (reset_n && mem_req) begin
        base = mem_addr;
        busy <= 1'b1;
        for (int k = 0; k < 4; k++) begin
          if (fill_gap != 4'h0) begin
            mem_ack <= 1'b0;
            beat_err <= 4'h0;
            mem_data <= ~mem_data; // Released bus never shows the last beat
            repeat (fill_gap) @(posedge clk_sys);
          end
          a = {base[31:5], base[4:3] + 2'(k), 3'h0};
          mem_ack <= 1'b1;
          mem_data <= {a, ~a};
          beat_err <= (k == err_beat) ? err_kind : 4'h0;
          @(posedge clk_sys);
          if (k == err_beat) break;
        end
        mem_ack <= 1'b0;
        beat_err <= 4'h0;
        mem_data <= ~mem_data;
        busy <= 1'b0;
      end
    end
  end
endmodule // cbf_mem_model

// file: sim/testbench.sv
// Self-checking bench for byte enables, miss forwarding and registers
`timescale 1ns/1ns
`include "cbf_cfg.svh"
module testbench;
  localparam logic [3:0] IMPLEMENTATION_FIELD = 4'hA; // Arbitrary value
  localparam logic [3:0] VERSION_FIELD = 4'h6; // Arbitrary value
  logic clk_sys = 1'b0, reset_n = 1'b0;
  logic [7:0] wb_adr_i = 8'h00, alt_space_id = 8'h04;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, internal_addr_bus = 32'h0, mem_addr, adr;
  logic wb_we_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_ack_o;
  logic [3:0] wb_sel_i = 4'hF, fill_gap = 4'h0, err_kind = 4'h0, beat_err;
  logic [2:0] err_beat = 3'h4;
  logic [1:0] access_size = 2'h0;
  logic [7:0] cache_byte_wr_en_n;
  logic cache_wr = 1'b0, miss_req = 1'b0, miss_dw = 1'b0, wr_d = 1'b0;
  logic cpu_hold, cpu_data_strobe, line_inval, mem_req, mem_ack, busy, irq;
  logic [63:0] internal_data_bus, mem_data, m;
  int errors = 0, checks = 0, cycles = 0, n_inval = 0, seed = 37882, fb = 0;
  logic fill_we;
  logic [1:0] fill_beat;
  logic [63:0] q_rd[$], q_rm[$], q_st[$];
  logic [7:0] q_be[$];
  cbf_top #(.IMPLEMENTATION_FIELD_ID(IMPLEMENTATION_FIELD), .VER_ID(VERSION_FIELD)) cbf_top_i (.clk_sys, .reset_n, .wb_adr_i,
    .wb_dat_i, .wb_dat_o, .wb_we_i, .wb_sel_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
    .alt_space_id, .cache_wr, .internal_addr_bus, .access_size, .cache_byte_wr_en_n,
    .miss_req, .miss_dw, .cpu_hold, .cpu_data_strobe, .internal_data_bus,
    .cache_fill_we(fill_we), .cache_fill_beat(fill_beat), .line_inval, .mem_req, .mem_addr,
    .mem_ack,
    .mem_data, .uncorrectable_error(beat_err[0]), .timeout_error(beat_err[1]),
    .bus_error(beat_err[2]), .mem_retry(beat_err[3]), .irq);
  cbf_mem_model cbf_mem_model_i (.clk_sys, .reset_n, .mem_req, .mem_addr, .fill_gap,
    .err_beat, .err_kind, .mem_ack, .mem_data, .beat_err, .busy);
  initial forever #5 clk_sys = ~clk_sys;
  task automatic cmp(input logic [63:0] got, input logic [63:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic print_verdict();
    $display("Counts: checks=%0d errors=%0d", checks, errors);
    if (errors == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Reads carry the expected value in dat; only bits in msk are compared
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] dat,
                    input logic [3:0] sel, input logic [31:0] msk);
    if (!we) begin
      q_rd.push_back(dat);
      q_rm.push_back(msk);
    end
    @(posedge clk_sys);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= dat;
    wb_sel_i <= sel;
    do @(posedge clk_sys); while (wb_ack_o !== 1'b1);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic irq_is(input logic v);
    repeat (2) @(posedge clk_sys);
    cmp(irq, v, "irq");
  endtask
  task automatic miss(input logic dw, input int nst, input int ninv, input logic early,
                      input int nfill);
    logic [31:0] a;
    int n0;
    n0 = n_inval;
    fb = 0;
    adr = $random(seed);
    for (int k = 0; k < nst; k++) begin
      a = {adr[31:5], adr[4:3] + 2'(k), 3'h0};
      q_st.push_back({a, ~a});
    end
    miss_req <= 1'b1;
    miss_dw <= dw;
    internal_addr_bus <= adr;
    @(posedge clk_sys);
    miss_req <= 1'b0;
    do @(posedge clk_sys); while (mem_req !== 1'b1);
    cmp(mem_addr, {adr[31:3], 3'h0}, "line address");
    do @(posedge clk_sys); while (cpu_hold !== 1'b0);
    cmp(busy, early, "fill running at hold release");
    while (busy) @(posedge clk_sys);
    repeat (3) @(posedge clk_sys);
    cmp(n_inval - n0, ninv, "line invalidations");
    cmp(fb, nfill, "fill beats written");
  endtask
  always @(posedge clk_sys) begin
    if (reset_n) begin
      if (wr_d) cmp(cache_byte_wr_en_n, q_be.pop_front(), "enables");
      else cmp(cache_byte_wr_en_n, 8'hFF, "idle enables");
      if (wb_ack_o && !wb_we_i) begin
        m = q_rm.pop_front();
        cmp(wb_dat_o & m, q_rd.pop_front() & m, "read data");
      end
      if (cpu_data_strobe) cmp(internal_data_bus, q_st.pop_front(), "strobe");
      if (line_inval) n_inval++;
      if (fill_we) begin
        cmp(fill_beat, 2'(adr[4:3] + 2'(fb)), "fill beat index");
        fb++;
      end
    end
    wr_d = cache_wr;
    cycles++;
    if (cycles == 20000) begin
      errors++;
      $display("ERROR %0t: run did not finish", $time);
      print_verdict();
    end
  end
  initial begin
    logic [8:0] ln;
    repeat (20) @(posedge clk_sys);
    reset_n <= 1'b1;
    wb(0, `CBF_OFS_SCR, {IMPLEMENTATION_FIELD, VERSION_FIELD, 24'h0} | `CBF_SCR_RESET, 4'hF, 32'hFFFFFFFF);
    wb(1, `CBF_OFS_SCR, 32'h0, 4'hF, 0);
    wb(1, `CBF_OFS_SCR, 32'hFFFFFFFF, 4'h4, 0);
    wb(0, `CBF_OFS_SCR, {IMPLEMENTATION_FIELD, VERSION_FIELD, 24'hFF0000}, 4'hF, 32'hFFFFFFFF);
    alt_space_id <= 8'h05 + 8'($random(seed) & 8'h70);
    wb(1, `CBF_OFS_SCR, 32'h0, 4'hF, 0);
    alt_space_id <= `CBF_CTRL_ASI;
    wb(0, `CBF_OFS_SCR, {IMPLEMENTATION_FIELD, VERSION_FIELD, 24'hFF0000}, 4'hF, 32'hFFFFFFFF);
    for (int r = 4; r <= 8'h1C; r += 4) begin
      if (r == 8'h10 || r == 8'h14 || r == 8'h18) continue;
      wb(1, 8'(r), 32'hFFFFFFFF, 4'hF, 0);
      wb(0, 8'(r), 32'h0, 4'hF, 32'hFFFFFFFF);
    end
    $display("Test registers done, errors=%0d", errors);
    for (int s = 0; s < 4; s++)
      for (int a = 0; a < 8; a += (1 << s)) begin
        ln = ((9'h001 << (1 << s)) - 9'h001) << a;
        q_be.push_back(~ln[7:0]);
        cache_wr <= 1'b1;
        access_size <= 2'(s);
        internal_addr_bus <= ($random(seed) & 32'hFFFFFFF8) | 32'(a);
        @(posedge clk_sys);
      end
    cache_wr <= 1'b0;
    $display("Test byte enables done, errors=%0d", errors);
    miss(1, 4, 0, 1, 4);
    fill_gap <= 4'h3;
    miss(0, 1, 0, 1, 4);
    irq_is(0);
    wb(1, `CBF_OFS_IRQ_EN, 32'h2, 4'hF, 0);
    irq_is(1);
    wb(1, `CBF_OFS_IRQ_CLR, 32'h3, 4'hF, 0);
    irq_is(0);
    wb(0, `CBF_OFS_IRQ_STAT, 32'h0, 4'hF, 32'h3);
    $display("Test forwarding done, errors=%0d", errors);
    wb(1, `CBF_OFS_IRQ_EN, 32'h1, 4'hF, 0);
    err_beat <= 3'h2;
    for (int k = 0; k < 4; k++) begin
      err_kind <= 4'(1 << k);
      miss(0, 1, 1, 1, 2);
      m = (64'h1 << `CBF_ASYNC_FAULT_STATUS_REG_SE_BIT) | (64'h1 << k);
      wb(0, `CBF_OFS_ASYNC_FAULT_STATUS_REG, m[31:0], 4'hF, m[31:0]);
      wb(0, `CBF_OFS_ASYNC_FAULT_ADDR_REG, {adr[31:3], 3'h0}, 4'hF, 32'hFFFFFFFF);
      irq_is(1);
      wb(1, `CBF_OFS_IRQ_CLR, 32'h1, 4'hF, 0);
      irq_is(0);
    end
    err_beat <= 3'h0;
    err_kind <= 4'h4;
    miss(1, 0, 0, 0, 0);
    err_beat <= 3'h4;
    wb(1, `CBF_OFS_SCR, 32'h0, 4'hF, 0);
    miss(1, 0, 0, 0, 4);
    $display("Test fill errors done, errors=%0d", errors);
    cmp(q_st.size() + q_be.size() + q_rd.size(), 0, "results left over");
    print_verdict();
  end
endmodule // testbench
